/* File: ifm_pkg.sv */
// ifm_pkg: constants and carrier types of the field memory mover
// assumes a 32-bit memory data path and byte-addressed registers
package ifm_pkg;
    // register byte offsets
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_WORDS = 8'h04;
    localparam logic [7:0] REG_BASE0 = 8'h08;
    localparam logic [7:0] REG_BASE1 = 8'h0C;
    localparam logic [7:0] REG_BASE2 = 8'h10;
    localparam logic [7:0] REG_STAT = 8'h14;
    // control and status fields and reset values
    localparam int CTRL_EN = 0;
    localparam int CTRL_DEPTH_LO = 1;
    localparam int CTRL_FB = 3;
    localparam int STAT_OVF = 4;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
    localparam logic [31:0] WORDS_RESET = 32'h0000_0000;
    localparam logic [31:0] BASE_RESET = 32'h0000_0000;
    localparam logic [1:0] DEPTH_12 = 2'h2;
    // packing: bits per pixel/error pair and per memory word
    localparam logic [6:0] PAIR_BITS_SHORT = 7'h28;
    localparam logic [6:0] PAIR_BITS_LONG = 7'h30;
    localparam logic [6:0] WORD_BITS = 7'h20;
    localparam logic [6:0] ACC_BITS = 7'h50;
    // burst shapes and outstanding limits
    localparam logic [8:0] AXI_BURST = 9'h020;
    localparam logic [8:0] FB_BURST = 9'h080;
    localparam logic [1:0] WR_OUT_AXI = 2'h1;
    localparam logic [1:0] WR_OUT_FB = 2'h2;
    localparam logic [1:0] RD_OUT_MAX = 2'h2;
    localparam logic [2:0] AXI_SIZE_WORD = 3'h2;
    localparam logic [1:0] AXI_INCR = 2'h1;
    localparam logic [3:0] STRB_FULL = 4'hF;
    localparam logic WR_ID = 1'h0;
    localparam logic [1:0] LAST_FIELD = 2'h2;
    typedef enum {WS_RUN, WS_FLUSH, WS_PAD, WS_DRAIN} ifm_wstate_t;
    typedef struct packed {
        logic id;
        logic [31:0] addr;
        logic [7:0] len;
    } ifm_addr_t;
    typedef struct packed {
        logic hblank;
        logic vblank;
        logic [47:0] pair;
    } ifm_vid_t;
endpackage : ifm_pkg

/* File: ifm_mover.sv */
// ifm_mover: video field packer, three-field store rotation and memory master
// assumes video pins asynchronous to clk_i; memory side is an AXI4 slave
//
// Chosen here: the Wishbone register port and the register offsets.
`timescale 1ns/100ps
`default_nettype none
module ifm_mover #(
    parameter int WBUF_DEPTH = 256,
    parameter int RBUF_DEPTH = 256
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic vid_clk_i,
    input wire logic vid_hblank_i,
    input wire logic vid_vblank_i,
    input wire logic [47:0] vid_pair_i,
    output logic vid_ce_o,
    output logic m_axi_awvalid_o,
    input wire logic m_axi_awready_i,
    output ifm_pkg::ifm_addr_t m_axi_aw_o,
    output logic [2:0] m_axi_awsize_o,
    output logic [1:0] m_axi_awburst_o,
    output logic [31:0] m_axi_wdata_o,
    output logic [3:0] m_axi_wstrb_o,
    output logic m_axi_wlast_o,
    output logic m_axi_wvalid_o,
    input wire logic m_axi_wready_i,
    input wire logic m_axi_bvalid_i,
    output logic m_axi_bready_o,
    output logic m_axi_arvalid_o,
    input wire logic m_axi_arready_i,
    output ifm_pkg::ifm_addr_t m_axi_ar_o,
    output logic [2:0] m_axi_arsize_o,
    output logic [1:0] m_axi_arburst_o,
    input wire logic m_axi_rvalid_i,
    input wire logic [31:0] m_axi_rdata_i,
    input wire logic m_axi_rid_i,
    input wire logic m_axi_rlast_i,
    output logic m_axi_rready_o,
    output logic [1:0][31:0] hist_data_o,
    output logic [1:0] hist_valid_o,
    input wire logic [1:0] hist_ready_i
);
    localparam int WAW = $clog2(WBUF_DEPTH);
    localparam int RAW = $clog2(RBUF_DEPTH);

    logic [31:0] ctrl;
    logic [31:0] field_words;
    logic [2:0][31:0] base;
    logic ovf;
    logic [7:0] frame_cnt;
    logic [1:0] field_idx;
    logic [1:0] fields_done;
    ifm_pkg::ifm_wstate_t wstate;

    // register bus: one wait state, ack dropped the cycle after; a write lands at the ack edge
    wire wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
    wire wb_wr = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o;
    wire [31:0] bmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [31:0] m);
        merge = (old & ~m) | (nw & m);
    endfunction : merge
    logic [1:0][1:0] rd_out;
    wire [31:0] stat_word = {8'h00, frame_cnt, 6'h00, rd_out[1], rd_out[0],
                             (wstate != ifm_pkg::WS_RUN), ovf, fields_done, field_idx};
    assign wb_dat_o = (wb_adr_i == ifm_pkg::REG_CTRL) ? ctrl :
                      (wb_adr_i == ifm_pkg::REG_WORDS) ? field_words :
                      (wb_adr_i == ifm_pkg::REG_BASE0) ? base[0] :
                      (wb_adr_i == ifm_pkg::REG_BASE1) ? base[1] :
                      (wb_adr_i == ifm_pkg::REG_BASE2) ? base[2] :
                      (wb_adr_i == ifm_pkg::REG_STAT) ? stat_word : 32'h0000_0000;
    wire en = ctrl[ifm_pkg::CTRL_EN];
    wire fb = ctrl[ifm_pkg::CTRL_FB];
    wire [1:0] depth = ctrl[ifm_pkg::CTRL_DEPTH_LO +: 2];
    wire [8:0] blen = fb ? ifm_pkg::FB_BURST : ifm_pkg::AXI_BURST;

    // configuration registers, reloaded through byte lanes
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            ctrl <= ifm_pkg::CTRL_RESET;
            field_words <= ifm_pkg::WORDS_RESET;
            base <= {3{ifm_pkg::BASE_RESET}};
        end else begin
            wb_ack_o <= wb_req;
            if (wb_wr && wb_adr_i == ifm_pkg::REG_CTRL) ctrl <= merge(ctrl, wb_dat_i, bmask);
            if (wb_wr && wb_adr_i == ifm_pkg::REG_WORDS) field_words <= merge(field_words, wb_dat_i, bmask);
            if (wb_wr && wb_adr_i == ifm_pkg::REG_BASE0) base[0] <= merge(base[0], wb_dat_i, bmask);
            if (wb_wr && wb_adr_i == ifm_pkg::REG_BASE1) base[1] <= merge(base[1], wb_dat_i, bmask);
            if (wb_wr && wb_adr_i == ifm_pkg::REG_BASE2) base[2] <= merge(base[2], wb_dat_i, bmask);
        end
    end

    // video pins: two flops each before any logic looks at them
    ifm_pkg::ifm_vid_t vid_s1, vid_s2;
    logic vclk_s1, vclk_s2, vclk_s3;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            {vclk_s1, vclk_s2, vclk_s3} <= 3'h0;
            vid_s1 <= '0;
            vid_s2 <= '0;
        end else begin
            vclk_s1 <= vid_clk_i;
            vclk_s2 <= vclk_s1;
            vclk_s3 <= vclk_s2;
            vid_s1 <= {vid_hblank_i, vid_vblank_i, vid_pair_i};
            vid_s2 <= vid_s1;
        end
    end
    // rise toggles the enable; fall samples data, which is then mid-period stable
    wire vrise = vclk_s2 && !vclk_s3;
    wire vfall = !vclk_s2 && vclk_s3;
    wire blank = vid_s2.hblank || vid_s2.vblank;
    logic ce_seen, vb_seen, field_on;
    wire take = vfall && ce_seen && en;
    wire sof = take && !blank && vb_seen;
    wire pix = take && !blank && (field_on || vb_seen);
    wire eof = vfall && vid_s2.vblank && field_on;

    // half-rate enable: one toggle per video clock gives an exact 50% duty
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            vid_ce_o <= 1'b0;
            ce_seen <= 1'b0;
            vb_seen <= 1'b0;
            field_on <= 1'b0;
            frame_cnt <= 8'h00;
        end else begin
            if (vrise) vid_ce_o <= !vid_ce_o;
            if (vrise) ce_seen <= vid_ce_o;
            if (vfall && vid_s2.vblank) vb_seen <= 1'b1;
            else if (sof) vb_seen <= 1'b0;
            if (sof) field_on <= 1'b1;
            else if (eof) field_on <= 1'b0;
            if (sof) frame_cnt <= frame_cnt + 8'h01;
        end
    end

    // packer: pairs enter a bit accumulator, 32-bit words leave it
    logic [79:0] acc;
    logic [6:0] acc_n;
    logic [WAW:0] wcnt, wpend;
    wire [6:0] pw = (depth == ifm_pkg::DEPTH_12) ? ifm_pkg::PAIR_BITS_LONG : ifm_pkg::PAIR_BITS_SHORT;
    wire [47:0] pmask = (depth == ifm_pkg::DEPTH_12) ? 48'hFFFF_FFFF_FFFF : 48'h00FF_FFFF_FFFF;
    logic [31:0] wr_fill;
    wire wfull = wcnt == (WAW+1)'(WBUF_DEPTH);
    wire pad_need = (wr_fill[8:0] & (blen - 9'h001)) != 9'h000;
    wire from_acc = !wfull && ((wstate == ifm_pkg::WS_RUN && acc_n >= ifm_pkg::WORD_BITS) ||
                               (wstate == ifm_pkg::WS_FLUSH && acc_n != 7'h00));
    wire push = from_acc || (!wfull && wstate == ifm_pkg::WS_PAD && pad_need);
    wire [31:0] push_data = from_acc ? acc[31:0] : 32'h0000_0000;
    wire [6:0] n_after = !from_acc ? acc_n : (acc_n >= ifm_pkg::WORD_BITS) ? acc_n - ifm_pkg::WORD_BITS : 7'h00;
    wire [7:0] n_room = {1'b0, n_after} + {1'b0, pw};
    wire pair_ok = pix && wstate != ifm_pkg::WS_FLUSH && n_room <= {1'b0, ifm_pkg::ACC_BITS};
    wire [79:0] acc_sh = from_acc ? {32'h0000_0000, acc[79:32]} : acc;
    wire [79:0] pair_ext = {32'h0000_0000, vid_s2.pair & pmask} << n_after;

    // 40-bit pairs give 5 words per 4 pairs, 48-bit pairs 3 words per 2
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            acc <= 80'h0;
            acc_n <= 7'h00;
        end else if (pair_ok) begin
            acc <= acc_sh | pair_ext;
            acc_n <= n_room[6:0];
        end else begin
            acc <= acc_sh;
            acc_n <= n_after;
        end
    end

    // write buffer and write channel
    logic [31:0] wbuf [WBUF_DEPTH];
    logic [WAW-1:0] wwp, wrp;
    logic [8:0] wbeat;
    logic [1:0] wout;
    logic [31:0] wr_off;
    wire [1:0] wout_max = fb ? ifm_pkg::WR_OUT_FB : ifm_pkg::WR_OUT_AXI;
    wire [WAW:0] wavail = wcnt - wpend;
    wire aw_go = en && !m_axi_awvalid_o && wout < wout_max && wavail >= (WAW+1)'(blen);
    wire w_hs = m_axi_wvalid_o && m_axi_wready_i;
    wire b_hs = m_axi_bvalid_i;
    assign m_axi_wvalid_o = wpend != '0;
    assign m_axi_wdata_o = wbuf[wrp];
    assign m_axi_wstrb_o = ifm_pkg::STRB_FULL;
    assign m_axi_wlast_o = wbeat == blen - 9'h001;
    assign m_axi_awsize_o = ifm_pkg::AXI_SIZE_WORD;
    assign m_axi_awburst_o = ifm_pkg::AXI_INCR;
    assign m_axi_bready_o = 1'b1;
    always_ff @(posedge clk_i) begin
        if (push) wbuf[wwp] <= push_data;
    end
    // pointer bookkeeping; a burst is claimed the cycle its command is raised
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            {wwp, wrp, wcnt, wpend, wbeat, wout} <= '0;
            m_axi_awvalid_o <= 1'b0;
            m_axi_aw_o <= '0;
        end else begin
            if (push) wwp <= wwp + 1'b1;
            if (w_hs) wrp <= wrp + 1'b1;
            wcnt <= wcnt + (WAW+1)'(push) - (WAW+1)'(w_hs);
            wpend <= wpend + (aw_go ? (WAW+1)'(blen) : '0) - (WAW+1)'(w_hs);
            if (w_hs) wbeat <= m_axi_wlast_o ? 9'h000 : wbeat + 9'h001;
            wout <= wout + 2'(aw_go) - 2'(b_hs);
            if (aw_go) begin
                m_axi_awvalid_o <= 1'b1;
                m_axi_aw_o <= '{id: ifm_pkg::WR_ID, addr: base[field_idx] + {wr_off[29:0], 2'h0},
                                len: 8'(blen - 9'h001)};
            end else if (m_axi_awready_i) begin
                m_axi_awvalid_o <= 1'b0;
            end
        end
    end

    // field sequencing: flush and pad at field end, then rotate the store
    wire drained = wcnt == '0 && wout == 2'h0 && !m_axi_awvalid_o;
    wire rotate = wstate == ifm_pkg::WS_DRAIN && drained;
    wire [1:0] nxt_idx = (field_idx == ifm_pkg::LAST_FIELD) ? 2'h0 : field_idx + 2'h1;
    wire ovf_set = pix && !pair_ok;
    wire ovf_clr = wb_wr && wb_adr_i == ifm_pkg::REG_STAT && wb_sel_i[0] && wb_dat_i[ifm_pkg::STAT_OVF];
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wstate <= ifm_pkg::WS_RUN;
            field_idx <= 2'h0;
            fields_done <= 2'h0;
            wr_off <= 32'h0;
            wr_fill <= 32'h0;
            ovf <= 1'b0;
        end else begin
            if (ovf_set) ovf <= 1'b1; // set beats clear
            else if (ovf_clr) ovf <= 1'b0;
            if (push) wr_fill <= wr_fill + 32'h1;
            if (aw_go) wr_off <= wr_off + 32'(blen);
            case (wstate)
                ifm_pkg::WS_RUN: begin
                    if (eof) wstate <= ifm_pkg::WS_FLUSH;
                end
                ifm_pkg::WS_FLUSH: begin
                    if (acc_n == 7'h00) wstate <= ifm_pkg::WS_PAD;
                end
                ifm_pkg::WS_PAD: begin
                    if (!pad_need) wstate <= ifm_pkg::WS_DRAIN;
                end
                ifm_pkg::WS_DRAIN: begin
                    if (drained) begin
                        wstate <= ifm_pkg::WS_RUN;
                        field_idx <= nxt_idx;
                        wr_off <= 32'h0;
                        wr_fill <= 32'h0;
                        if (fields_done != ifm_pkg::LAST_FIELD) fields_done <= fields_done + 2'h1;
                    end
                end
                default: wstate <= ifm_pkg::WS_RUN;
            endcase
        end
    end

    // read side: stream 0 is the newest history field, stream 1 the older one
    logic [1:0] rd_want, rd_go;
    logic prio;
    wire [1:0][1:0] rfield = {(field_idx == 2'h0) ? 2'h1 : (field_idx == 2'h1) ? 2'h2 : 2'h0,
                              (field_idx == 2'h0) ? 2'h2 : field_idx - 2'h1};
    wire any_want = |rd_want;
    wire pick = rd_want[prio] ? prio : !prio;
    assign rd_go = (!m_axi_arvalid_o && any_want) ? (pick ? 2'h2 : 2'h1) : 2'h0;
    assign m_axi_rready_o = 1'b1;
    assign m_axi_arsize_o = ifm_pkg::AXI_SIZE_WORD;
    assign m_axi_arburst_o = ifm_pkg::AXI_INCR;

    for (genvar s = 0; s < 2; s++) begin : g_rd
        localparam logic SID = 1'(s);
        logic [31:0] rmem [RBUF_DEPTH];
        logic [RAW-1:0] wp, rp;
        logic [RAW:0] cnt;
        logic [31:0] iss, rcv;
        logic [1:0] out;
        logic restart;
        wire hit = m_axi_rvalid_i && m_axi_rid_i == SID;
        wire keep = hit && rcv < field_words;
        wire pop = hist_valid_o[s] && hist_ready_i[s];
        wire [RAW+2:0] claim = (RAW+3)'(cnt) + (RAW+3)'(blen) * (RAW+3)'(out) + (RAW+3)'(blen);
        assign rd_want[s] = en && !restart && fields_done > SID && iss < field_words &&
                            out < ifm_pkg::RD_OUT_MAX && claim <= (RAW+3)'(RBUF_DEPTH);
        assign rd_out[s] = out;
        assign hist_valid_o[s] = cnt != '0;
        assign hist_data_o[s] = rmem[rp];
        always_ff @(posedge clk_i) begin
            if (keep) rmem[wp] <= m_axi_rdata_i;
        end
        always_ff @(posedge clk_i) begin
            if (rst_i) begin
                {wp, rp, cnt, iss, rcv, out} <= '0;
                restart <= 1'b0;
            end else begin
                if (keep) wp <= wp + 1'b1;
                if (pop) rp <= rp + 1'b1;
                cnt <= cnt + (RAW+1)'(keep) - (RAW+1)'(pop);
                out <= out + 2'(rd_go[s]) - 2'(hit && m_axi_rlast_i);
                if (rotate) restart <= 1'b1;
                else if (restart && out == 2'h0) restart <= 1'b0;
                if (restart && out == 2'h0) begin
                    iss <= 32'h0;
                    rcv <= 32'h0;
                end else begin
                    if (rd_go[s]) iss <= iss + 32'(blen);
                    if (hit) rcv <= rcv + 32'h1;
                end
            end
        end
    end

    // one read command register shared by both ids, turns alternate
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            m_axi_arvalid_o <= 1'b0;
            m_axi_ar_o <= '0;
            prio <= 1'b0;
        end else if (any_want && !m_axi_arvalid_o) begin
            m_axi_arvalid_o <= 1'b1;
            prio <= !pick;
            m_axi_ar_o <= '{id: pick, len: 8'(blen - 9'h001),
                            addr: base[rfield[pick]] + {(pick ? g_rd[1].iss[29:0] : g_rd[0].iss[29:0]), 2'h0}};
        end else if (m_axi_arready_i) begin
            m_axi_arvalid_o <= 1'b0;
        end
    end

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    a_aw_len_fixed: assert property (m_axi_awvalid_o && !fb |-> m_axi_aw_o.len == 8'h1F)
        else $error("write burst length is not 32 beats");
    a_ar_len_fixed: assert property (m_axi_arvalid_o && !fb |-> m_axi_ar_o.len == 8'h1F)
        else $error("read burst length is not 32 beats");
    a_wr_one_out: assert property (!fb |-> wout <= 2'h1)
        else $error("more than one write outstanding");
    a_aw_has_data: assert property ($rose(m_axi_awvalid_o) |-> wcnt >= (WAW+1)'(blen))
        else $error("write requested without buffered data");
    a_rd_out_max: assert property (rd_out[0] <= 2'h2 && rd_out[1] <= 2'h2)
        else $error("too many reads outstanding");
    a_rready_high: assert property (m_axi_rready_o)
        else $error("read ready dropped");
    a_ar_hold: assert property (m_axi_arvalid_o && !m_axi_arready_i |=>
        m_axi_arvalid_o && $stable(m_axi_ar_o))
        else $error("read command changed before acceptance");
    a_ce_toggle: assert property (vrise |=> vid_ce_o != $past(vid_ce_o))
        else $error("clock enable did not toggle on video edge");
    a_pad_boundary: assert property (wstate == ifm_pkg::WS_DRAIN |-> !pad_need)
        else $error("field ended off a burst boundary");
    a_rot_order: assert property (rotate |=>
        field_idx == ($past(field_idx) == 2'h2 ? 2'h0 : $past(field_idx) + 2'h1))
        else $error("field store rotation out of order");
    c_aw_taken: cover property (m_axi_awvalid_o && m_axi_awready_i);
    c_rd_id1_last: cover property (m_axi_rvalid_i && m_axi_rid_i && m_axi_rlast_i);
    c_rotate: cover property (rotate);
    c_two_reads: cover property (rd_out[0] == 2'h2);
endmodule : ifm_mover
`default_nettype wire

/* File: ifm_axi_mem.sv */
// ifm_axi_mem: behavioural axi4 memory slave facing the field mover
// assumes bready and rready are tied high by the master, one clock
`timescale 1ns/100ps
`default_nettype none
module ifm_axi_mem (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic awvalid_i,
    input wire ifm_pkg::ifm_addr_t aw_i,
    output logic awready_o,
    input wire logic [31:0] wdata_i,
    input wire logic wvalid_i,
    input wire logic wlast_i,
    output logic wready_o,
    output logic bvalid_o,
    input wire logic arvalid_i,
    input wire ifm_pkg::ifm_addr_t ar_i,
    output logic arready_o,
    output logic rvalid_o,
    output logic [31:0] rdata_o,
    output logic rid_o,
    output logic rlast_o
);
    logic [31:0] mem [logic [31:0]];
    logic [31:0] aq [$], wd [$], wa, ra;
    int bl [$], wc, rb;
    ifm_pkg::ifm_addr_t rq [$], cur;
    logic busy;
    // data may lead its address, so a burst lands only once both are in
    always @(posedge clk_i) begin
        if (rst_i) begin
            {awready_o, wready_o, bvalid_o, arready_o, rvalid_o, rlast_o} <= 6'h00;
            busy = 1'b0;
            wc = 0;
        end else begin
            awready_o <= awvalid_i && !awready_o && ($urandom % 3 == 0);
            wready_o <= ($urandom % 4 != 0);
            if (awvalid_i && awready_o) aq.push_back(aw_i.addr);
            if (wvalid_i && wready_o) begin
                wd.push_back(wdata_i);
                wc++;
                if (wlast_i) begin
                    bl.push_back(wc);
                    wc = 0;
                end
            end
            bvalid_o <= 1'b0;
            if (!bvalid_o && aq.size() > 0 && bl.size() > 0) begin
                wa = aq.pop_front();
                for (int i = 0; i < bl[0]; i++) mem[wa + 4 * i] = wd.pop_front();
                void'(bl.pop_front());
                bvalid_o <= 1'b1;
            end
            // reads are served in arrival order; idle data lines wander
            arready_o <= arvalid_i && !arready_o && ($urandom % 2 == 0);
            if (arvalid_i && arready_o) rq.push_back(ar_i);
            if (!busy && rq.size() > 0) begin
                cur = rq.pop_front();
                rb = 0;
                busy = 1'b1;
            end
            if (busy && $urandom % 3 != 0) begin
                ra = cur.addr + 4 * rb;
                rvalid_o <= 1'b1;
                rid_o <= cur.id;
                rdata_o <= mem.exists(ra) ? mem[ra] : 32'h0;
                rlast_o <= (rb == cur.len);
                busy = (rb != cur.len);
                rb++;
            end else begin
                rvalid_o <= 1'b0;
                rlast_o <= 1'b0;
                rdata_o <= ~rdata_o;
            end
        end
    end
endmodule : ifm_axi_mem
`default_nettype wire

/* File: tb_ifm_mover.sv */
// tb_ifm_mover: random fields through the mover into a memory model
// assumes the mover's register map and a 160 ns video clock source
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin n_fail++; $display("wrong value at %0t: mismatch", $time); end end
module tb_ifm_mover;
    logic clk_i = 1'b0, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, vid_clk_i, vid_hblank_i, vid_vblank_i, vid_ce_o;
    logic [7:0] wb_adr_i;
    logic [3:0] wb_sel_i, m_axi_wstrb_o;
    logic [31:0] wb_dat_i, wb_dat_o, m_axi_wdata_o, m_axi_rdata_i, q, b [3], ex [$], e0 [$], hq [$], hq1 [$];
    logic [47:0] vid_pair_i;
    logic m_axi_awvalid_o, m_axi_awready_i, m_axi_wlast_o, m_axi_wvalid_o, m_axi_wready_i, m_axi_bvalid_i;
    logic m_axi_bready_o, m_axi_arvalid_o, m_axi_arready_i, m_axi_rvalid_i, m_axi_rid_i, m_axi_rlast_i;
    logic m_axi_rready_o, cep, h;
    ifm_pkg::ifm_addr_t m_axi_aw_o, m_axi_ar_o;
    logic [2:0] m_axi_awsize_o, m_axi_arsize_o;
    logic [1:0] m_axi_awburst_o, m_axi_arburst_o, hist_valid_o, hist_ready_i;
    logic [1:0][31:0] hist_data_o;
    logic [127:0] acc;
    int n_fail, checks, nacc, wo, beats, ro [2];
    ifm_mover i_dut (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o,
        .wb_ack_o, .vid_clk_i, .vid_hblank_i, .vid_vblank_i, .vid_pair_i, .vid_ce_o, .m_axi_awvalid_o,
        .m_axi_awready_i, .m_axi_aw_o, .m_axi_awsize_o, .m_axi_awburst_o, .m_axi_wdata_o, .m_axi_wstrb_o,
        .m_axi_wlast_o, .m_axi_wvalid_o, .m_axi_wready_i, .m_axi_bvalid_i, .m_axi_bready_o, .m_axi_arvalid_o,
        .m_axi_arready_i, .m_axi_ar_o, .m_axi_arsize_o, .m_axi_arburst_o, .m_axi_rvalid_i, .m_axi_rdata_i,
        .m_axi_rid_i, .m_axi_rlast_i, .m_axi_rready_o, .hist_data_o, .hist_valid_o, .hist_ready_i);
    ifm_axi_mem i_mem (.clk_i, .rst_i, .awvalid_i(m_axi_awvalid_o), .aw_i(m_axi_aw_o), .awready_o(m_axi_awready_i),
        .wdata_i(m_axi_wdata_o), .wvalid_i(m_axi_wvalid_o), .wlast_i(m_axi_wlast_o), .wready_o(m_axi_wready_i),
        .bvalid_o(m_axi_bvalid_i), .arvalid_i(m_axi_arvalid_o), .ar_i(m_axi_ar_o), .arready_o(m_axi_arready_i),
        .rvalid_o(m_axi_rvalid_i), .rdata_o(m_axi_rdata_i), .rid_o(m_axi_rid_i), .rlast_o(m_axi_rlast_i));
    always #10 clk_i = ~clk_i;
    // offset by 3 ns so video edges never meet system clock edges
    initial begin
        vid_clk_i = 1'b0;
        #3;
        forever #80 vid_clk_i = ~vid_clk_i;
    end
    task final_report;
        $display("checks %0d n_fail %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : final_report
    task wb_io(input logic we, input logic [7:0] a, input logic [31:0] d);
        int t;
        @(posedge clk_i);
        {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i, wb_sel_i} <= {2'h3, we, a, d, 4'hF};
        t = 0;
        do begin
            @(posedge clk_i);
            t++;
        end while (wb_ack_o !== 1'b1 && t < 50);
        q = wb_dat_o;
        {wb_cyc_i, wb_stb_i} <= 2'h0;
        if (t >= 50) begin n_fail++; final_report; end
    endtask : wb_io
    // expected memory image: pairs laid lsb first into 32-bit words
    function void add(input logic [47:0] p, input int w);
        acc = acc | (({80'h0, p} & ((128'h1 << w) - 1)) << nacc);
        nacc += w;
        while (nacc >= 32) begin
            ex.push_back(acc[31:0]);
            acc = acc >> 32;
            nacc -= 32;
        end
    endfunction : add
    // source paces on the clock enable, hblank slots and vblank carry junk
    task send_field(input int n, input int w);
        int k, t;
        logic [47:0] p;
        {k, t, nacc, acc, h} = 0;
        ex.delete();
        while (k < n && t < 2000) begin
            @(posedge vid_clk_i);
            t++;
            p = {16'($urandom), $urandom};
            if (vid_ce_o === 1'b1) begin
                vid_vblank_i <= 1'b0;
                vid_hblank_i <= (k % 16 == 8) && !h;
                h = (k % 16 == 8) && !h;
                if (!h) begin
                    vid_pair_i <= p;
                    add(p, w);
                    k++;
                end
            end
        end
        if (t >= 2000) begin n_fail++; final_report; end
        @(posedge vid_clk_i);
        vid_vblank_i <= 1'b1;
        repeat (8) @(posedge vid_clk_i) vid_pair_i <= {16'($urandom), $urandom};
    endtask : send_field
    task chk_field(input logic [31:0] a, input int n);
        int t;
        for (t = 0; t < 20000 && !i_mem.mem.exists(a + 4 * (n - 1)); t++) @(posedge clk_i);
        if (t >= 20000) begin n_fail++; final_report; end
        for (int i = 0; i < n; i++) `CHK(i_mem.mem[a + 4 * i], (i < ex.size()) ? ex[i] : 32'h0)
    endtask : chk_field
    // bus monitor and history consumer
    always @(posedge clk_i) begin
        hist_ready_i <= 2'($urandom);
        if (hist_valid_o[0] && hist_ready_i[0]) hq.push_back(hist_data_o[0]);
        if (hist_valid_o[1] && hist_ready_i[1]) hq1.push_back(hist_data_o[1]);
        if (!rst_i) begin
            if (m_axi_awvalid_o === 1'b1)
                `CHK({m_axi_aw_o.len, m_axi_awsize_o}, {8'h1F, ifm_pkg::AXI_SIZE_WORD})
            wo += (m_axi_awvalid_o && m_axi_awready_i) - m_axi_bvalid_i;
            `CHK(wo <= 1, 1'b1)
            if (m_axi_wvalid_o && m_axi_wready_i) begin
                beats++;
                `CHK({m_axi_wstrb_o, m_axi_wlast_o}, {ifm_pkg::STRB_FULL, beats == 32})
                if (m_axi_wlast_o) beats = 0;
            end
            if (m_axi_arvalid_o === 1'b1)
                `CHK({m_axi_ar_o.len, m_axi_arsize_o}, {8'h1F, ifm_pkg::AXI_SIZE_WORD})
            `CHK({m_axi_awburst_o, m_axi_arburst_o}, {2{ifm_pkg::AXI_INCR}})
            if (m_axi_arvalid_o && m_axi_arready_i) ro[m_axi_ar_o.id]++;
            if (m_axi_rvalid_i && m_axi_rlast_i) ro[m_axi_rid_i]--;
            `CHK({ro[0] <= 2, ro[1] <= 2, m_axi_rready_o}, 3'h7)
        end
    end
    // enable must flip between every two video clock rises
    always @(posedge vid_clk_i) begin
        if (!rst_i && cep !== 1'bx) `CHK(vid_ce_o, ~cep)
        cep = rst_i ? 1'bx : vid_ce_o;
    end
    initial begin
        {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i, wb_dat_i, vid_hblank_i, vid_pair_i} = 0;
        {rst_i, vid_vblank_i} = 2'h3;
        {n_fail, checks, wo, beats, ro[0], ro[1]} = 192'h0;
        void'($urandom(32'hDBB2D2EC));
        repeat (5) @(posedge clk_i);
        rst_i <= 1'b0;
        wb_io(1'b0, ifm_pkg::REG_CTRL, 32'h0);
        `CHK(q, ifm_pkg::CTRL_RESET)
        for (int i = 0; i < 3; i++) begin
            b[i] = ($urandom & 32'hFFF0_0000) | (32'(i) << 16);
            wb_io(1'b1, ifm_pkg::REG_BASE0 + 8'(4 * i), b[i]);
            wb_io(1'b0, ifm_pkg::REG_BASE0 + 8'(4 * i), 32'h0);
            `CHK(q, b[i])
        end
        wb_io(1'b1, ifm_pkg::REG_WORDS, 32'h60);
        wb_io(1'b0, 8'h40, 32'h0);
        `CHK(q, 32'h0)
        wb_io(1'b1, ifm_pkg::REG_CTRL, 32'h1);
        send_field(64, 40);
        e0 = ex;
        chk_field(b[0], 96);
        wb_io(1'b1, ifm_pkg::REG_CTRL, 32'h5);
        send_field(32, 48);
        chk_field(b[1], 64);
        `CHK(hq.size() >= 80, 1'b1)
        for (int i = 0; i < 80 && i < hq.size(); i++) `CHK(hq[i], e0[i])
        // the older history stream starts once two fields are stored; a missing word reads as unknown
        for (int t = 0; t < 5000 && hq1.size() < 80; t++) @(posedge clk_i);
        for (int i = 0; i < 80; i++) `CHK(hq1[i], e0[i])
        final_report;
    end
endmodule : tb_ifm_mover
`default_nettype wire
